// >>> dual_timer_counter_unit.sv
// Purpose: Two timer/counters with mode, run and flag registers on APB
// Assumes: Pins are asynchronous; acks come from logic on clk_sys
// Notes:   Counting and sampling are timed by machine cycle strobes
// Operation
// - Timer function counts once per machine cycle
// - Counter samples pin once, counts falling edge
// - Edge count appears at next update phase
// - Mode 0 is 13-bit, wrap sets flag
// - Count only when run and gate allow, except split TH0 (TR1 alone) and timer 1 while timer 0 splits (gate alone)
// - Mode 1 is full 16-bit, wrap sets flag
// - Mode 2 low byte reloads from high
// - Timer 1 in mode 3 holds count
// - Timer 0 mode 3 splits into two bytes
// - Mode register nibbles and mode encodings
// - Gate bit lets interrupt pin enable counting
// - Function bit selects cycles or pin edges
// - Overflow flag set on wrap, cleared on vector
// - Interrupt 0 flag set, edge mode clears
// - Type bit picks low level or falling edge
// - Mode and control registers reset to zero
// - Absent pins give no count or gating
module dual_timer_counter_unit
   import timer_pkg::*;
#(
   parameter bit HAS_T0_PIN   = 1'b0,
   parameter bit HAS_EXT_IRQ1_PIN_PIN = 1'b0
) (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire apb_req_t    apb_req,
   output apb_rsp_t         apb_rsp,
   input  wire timer_pins_t pins,
   input  wire vector_ack_t vector_ack,
   output logic             timer0_overflow_flag,
   output logic             timer1_overflow_flag,
   output logic             ext_irq0_request_flag
);

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic [3:0]  ph;
      logic        fast;
      logic [7:0]  timer_mode_select;
      logic        tf1;
      logic        tr1;
      logic        tf0;
      logic        tr0;
      logic        ie0;
      logic        it0;
      logic [7:0]  tl0;
      logic [7:0]  th0;
      logic [7:0]  tl1;
      logic [7:0]  th1;
      logic [2:0]  sy_c0;
      logic [2:0]  sy_c1;
      logic [2:0]  sy_i0;
      logic [2:0]  sy_i1;
      logic        lv_c0;
      logic        lv_c1;
      logic        lv_i0;
      logic        lv_i1;
      logic        sm_c0;
      logic        sm_c1;
      logic        sm_i0;
      logic        pend0;
      logic        pend1;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_t;

   localparam state_t STATE_RST = '{
      ph: 4'h0, fast: 1'b0, timer_mode_select: RST_MODE_SELECT,
      tf1: RST_RUN_FLAG_CTRL[TF1_POS], tr1: RST_RUN_FLAG_CTRL[TR1_POS],
      tf0: RST_RUN_FLAG_CTRL[TF0_POS], tr0: RST_RUN_FLAG_CTRL[TR0_POS],
      ie0: RST_RUN_FLAG_CTRL[IE0_POS], it0: RST_RUN_FLAG_CTRL[IT0_POS],
      tl0: RST_COUNT, th0: RST_COUNT, tl1: RST_COUNT, th1: RST_COUNT,
      sy_c0: 3'h7, sy_c1: 3'h7, sy_i0: 3'h7, sy_i1: 3'h7,
      lv_c0: 1'b1, lv_c1: 1'b1, lv_i0: 1'b1, lv_i1: 1'b1,
      sm_c0: 1'b1, sm_c1: 1'b1, sm_i0: 1'b1, pend0: 1'b0, pend1: 1'b0,
      prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};

   state_t r;
   state_t r_nxt;

   // ***********************************************************
   // Helpers
   // ***********************************************************
   // Returns {overflow, high byte, low byte} after one count step
   function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] tl,
                                        input logic [7:0] th);
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0]  s8;
      s13 = {1'b0, th, tl[4:0]} + 14'h0001;
      s16 = {1'b0, th, tl} + 17'h00001;
      s8  = {1'b0, tl} + 9'h001;
      case (m)
         MODE_13:     step = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
         MODE_16:     step = s16;
         MODE_RELOAD: step = {s8[8], th, (s8[8] ? th : s8[7:0])};
         default:     step = {s8[8], th, s8[7:0]};
      endcase
   endfunction

   function automatic logic [2:0] sync3(input logic [2:0] s, input logic pin);
      sync3 = {s[1:0], pin};
   endfunction

   // A change counts once the second and third stages agree
   function automatic logic settle(input logic [2:0] s, input logic lv);
      settle = (s[1] == s[2]) ? s[2] : lv;
   endfunction

   logic [1:0] m0;
   logic [1:0] m1;
   logic       split;
   logic       upd;
   logic       smp;
   logic       acc;
   logic       wr_any;
   logic [7:0] idx;
   logic       hit;
   logic       set_tf0;
   logic       set_tf1;
   logic       run0;
   logic       run1;
   logic       inc0;
   logic       inc0h;
   logic       inc1;

   assign m0    = r.timer_mode_select[T0_M_HI:T0_M_LO];
   assign m1    = r.timer_mode_select[T1_M_HI:T1_M_LO];
   assign split = (m0 == MODE_SPLIT);
   assign upd   = (r.ph == 4'h0);
   assign smp   = (r.ph >= (r.fast ? LAST_FAST : LAST_STD));
   assign acc   = apb_req.psel & apb_req.penable;
   assign idx   = apb_req.paddr[9:2];
   assign hit   = (apb_req.paddr[1:0] == 2'h0)
                & (apb_req.paddr[APB_ADDR_W-1:10] == '0)
                & ((idx == IDX_RUN_FLAG_CTRL) | (idx == IDX_MODE_SELECT)
                 | (idx == IDX_T0_LOW) | (idx == IDX_T0_HIGH) | (idx == IDX_T1_LOW)
                 | (idx == IDX_T1_HIGH) | (idx == IDX_CYCLE_CTRL));
   assign wr_any = acc & r.pready & apb_req.pwrite;

   assign run0  = r.tr0 & (~r.timer_mode_select[T0_GATE] | r.lv_i0);
   assign run1  = (split | r.tr1) & (~r.timer_mode_select[T1_GATE] | r.lv_i1);
   assign inc0  = upd & run0 & (r.timer_mode_select[T0_CT] ? r.pend0 : 1'b1);
   // High byte of split timer 0 runs on timer 1 run bit
   assign inc0h = upd & split & r.tr1;
   // Timer 1 held in mode 3
   assign inc1  = upd & run1 & (m1 != MODE_SPLIT) & (r.timer_mode_select[T1_CT] ? r.pend1 : 1'b1);

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      logic [16:0] s0;
      logic [16:0] s1;
      logic [8:0]  sh;
      logic [7:0]  rd;
      rd = 8'h00;
      r_nxt = r;
      s0 = step(m0, r.tl0, r.th0);
      s1 = step(m1, r.tl1, r.th1);
      sh = {1'b0, r.th0} + 9'h001;
      set_tf0 = 1'b0;
      set_tf1 = 1'b0;
      r_nxt.ph = smp ? 4'h0 : r.ph + 4'h1;

      // Missing pins read as idle high
      r_nxt.sy_c0 = sync3(r.sy_c0, HAS_T0_PIN ? pins.timer0_count_pin : 1'b1);
      r_nxt.sy_c1 = sync3(r.sy_c1, pins.timer1_count_pin);
      r_nxt.sy_i0 = sync3(r.sy_i0, pins.ext_irq0_pin);
      r_nxt.sy_i1 = sync3(r.sy_i1, HAS_EXT_IRQ1_PIN_PIN ? pins.ext_irq1_pin : 1'b1);
      r_nxt.lv_c0 = settle(r.sy_c0, r.lv_c0);
      r_nxt.lv_c1 = settle(r.sy_c1, r.lv_c1);
      r_nxt.lv_i0 = settle(r.sy_i0, r.lv_i0);
      r_nxt.lv_i1 = settle(r.sy_i1, r.lv_i1);

      // Pending edge consumed at next update phase
      if (upd) begin
         r_nxt.pend0 = 1'b0;
         r_nxt.pend1 = 1'b0;
      end
      // Sample once per cycle, high then low counts
      if (smp) begin
         r_nxt.sm_c0 = r.lv_c0;
         r_nxt.sm_c1 = r.lv_c1;
         r_nxt.sm_i0 = r.lv_i0;
         if (r.sm_c0 & ~r.lv_c0) begin
            r_nxt.pend0 = 1'b1;
         end
         if (r.sm_c1 & ~r.lv_c1) begin
            r_nxt.pend1 = 1'b1;
         end
      end

      if (inc0) begin
         r_nxt.tl0 = s0[7:0];
         r_nxt.th0 = s0[15:8];
         set_tf0   = s0[16];
      end
      if (inc0h) begin
         r_nxt.th0 = sh[7:0];
         set_tf1   = sh[8];
      end
      if (inc1) begin
         r_nxt.tl1 = s1[7:0];
         r_nxt.th1 = s1[15:8];
         set_tf1   = set_tf1 | (s1[16] & ~split);
      end

      // Bus read and write
      case (idx)
         IDX_RUN_FLAG_CTRL: rd = {r.tf1, r.tr1, r.tf0, r.tr0, 2'b00, r.ie0, r.it0};
         IDX_MODE_SELECT:   rd = r.timer_mode_select;
         IDX_T0_LOW:        rd = r.tl0;
         IDX_T0_HIGH:       rd = r.th0;
         IDX_T1_LOW:        rd = r.tl1;
         IDX_T1_HIGH:       rd = r.th1;
         IDX_CYCLE_CTRL:    rd = {7'h00, r.fast};
         default:           rd = 8'h00;
      endcase
      r_nxt.pready = acc & ~r.pready;
      if (acc & ~r.pready) begin
         r_nxt.prdata  = {24'h000000, (hit ? rd : 8'h00)};
         r_nxt.pslverr = ~hit;
      end else if (~acc) begin
         r_nxt.pslverr = 1'b0;
      end
      if (wr_any & hit) begin
         case (idx)
            IDX_RUN_FLAG_CTRL: begin
               r_nxt.tf1 = apb_req.pwdata[TF1_POS];
               r_nxt.tr1 = apb_req.pwdata[TR1_POS];
               r_nxt.tf0 = apb_req.pwdata[TF0_POS];
               r_nxt.tr0 = apb_req.pwdata[TR0_POS];
               r_nxt.ie0 = apb_req.pwdata[IE0_POS];
               r_nxt.it0 = apb_req.pwdata[IT0_POS];
            end
            IDX_MODE_SELECT: r_nxt.timer_mode_select = apb_req.pwdata[7:0];
            IDX_T0_LOW:      r_nxt.tl0  = apb_req.pwdata[7:0];
            IDX_T0_HIGH:     r_nxt.th0  = apb_req.pwdata[7:0];
            IDX_T1_LOW:      r_nxt.tl1  = apb_req.pwdata[7:0];
            IDX_T1_HIGH:     r_nxt.th1  = apb_req.pwdata[7:0];
            IDX_CYCLE_CTRL:  r_nxt.fast = apb_req.pwdata[FAST_POS];
            default:         r_nxt.fast = r.fast;
         endcase
      end

      if (vector_ack.timer0_ack) begin
         r_nxt.tf0 = 1'b0;
      end
      if (vector_ack.timer1_ack) begin
         r_nxt.tf1 = 1'b0;
      end
      if (set_tf0) begin
         r_nxt.tf0 = 1'b1;
      end
      if (set_tf1) begin
         r_nxt.tf1 = 1'b1;
      end

      // Edge flag cleared on vector; level mode follows pin
      // Type bit picks level or falling edge
      if (vector_ack.ext_irq0_ack & r.it0) begin
         r_nxt.ie0 = 1'b0;
      end
      if (smp) begin
         if (r.it0) begin
            if (r.sm_i0 & ~r.lv_i0) begin
               r_nxt.ie0 = 1'b1;
            end
         end else begin
            r_nxt.ie0 = ~r.lv_i0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         r <= STATE_RST;
      end else begin
         r <= r_nxt;
      end
   end

   assign apb_rsp               = '{prdata: r.prdata, pready: r.pready, pslverr: r.pslverr};
   assign timer0_overflow_flag  = r.tf0;
   assign timer1_overflow_flag  = r.tf1;
   assign ext_irq0_request_flag = r.ie0;

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence t0_plain_16;
      upd && m0 == MODE_16 && !r.timer_mode_select[T0_CT] && !r.timer_mode_select[T0_GATE] && r.tr0 && !wr_any;
   endsequence
   sequence t1_edge_16;
      upd && m1 == MODE_16 && r.timer_mode_select[T1_CT] && !r.timer_mode_select[T1_GATE] && r.tr1 && !split
         && !wr_any;
   endsequence

   chk_cycle_std: assert property ((r.ph == LAST_STD) |=> upd)
      else $error("machine cycle longer than twelve clocks");
   chk_cycle_fast: assert property ((r.fast && r.ph == LAST_FAST) |=> upd)
      else $error("fast machine cycle not six clocks");
   chk_timer_step: assert property (t0_plain_16 |=>
      {r.th0, r.tl0} == $past({r.th0, r.tl0}) + 16'h0001)
      else $error("timer 0 did not advance one per cycle");
   chk_edge_count: assert property ((t1_edge_16 and r.pend1) |=>
      {r.th1, r.tl1} == $past({r.th1, r.tl1}) + 16'h0001)
      else $error("detected edge not counted at update");
   chk_no_edge_hold: assert property ((t1_edge_16 and !r.pend1) |=>
      $stable({r.th1, r.tl1}))
      else $error("counter moved without an edge");
   chk_mode0_wrap: assert property ((upd && m0 == MODE_13 && run0 && !r.timer_mode_select[T0_CT]
      && r.th0 == 8'hFF && r.tl0[4:0] == 5'h1F) |=> r.tf0 && r.th0 == 8'h00)
      else $error("13-bit wrap did not set flag");
   chk_reload: assert property ((upd && m0 == MODE_RELOAD && run0 && !r.timer_mode_select[T0_CT]
      && r.tl0 == 8'hFF && !wr_any) |=> r.tf0 && r.tl0 == $past(r.th0) && $stable(r.th0))
      else $error("reload from high byte failed");
   chk_t1_hold: assert property ((m1 == MODE_SPLIT && !wr_any) |=>
      $stable({r.th1, r.tl1}))
      else $error("timer 1 counted in mode 3");
   chk_split_high: assert property ((inc0h && !wr_any && r.th0 == 8'hFF) |=>
      r.tf1 && r.th0 == 8'h00)
      else $error("split high byte did not set timer 1 flag");
   chk_run_off: assert property ((!r.tr0 && !split && !wr_any) |=>
      $stable({r.th0, r.tl0}))
      else $error("timer 0 counted while stopped");
   chk_flag_clear: assert property ((vector_ack.timer0_ack && !set_tf0) |=> !r.tf0)
      else $error("vector did not clear timer 0 flag");
   chk_irq_level: assert property ((smp && !r.it0) |=> r.ie0 == !$past(r.lv_i0))
      else $error("level flag does not follow pin");

endmodule // dual_timer_counter_unit

// >>> timer_pkg.sv
// Purpose: Shared constants and carrier types of the dual timer/counter unit
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   Register byte address is four times the register index
package timer_pkg;

   // ***********************************************************
   // Register indices (byte address = index * 4)
   // ***********************************************************
   localparam logic [7:0] IDX_RUN_FLAG_CTRL = 8'h88;
   localparam logic [7:0] IDX_MODE_SELECT   = 8'h89;
   localparam logic [7:0] IDX_T0_LOW        = 8'hA0;
   localparam logic [7:0] IDX_T0_HIGH       = 8'hA1;
   localparam logic [7:0] IDX_T1_LOW        = 8'hA2;
   localparam logic [7:0] IDX_T1_HIGH       = 8'hA3;
   localparam logic [7:0] IDX_CYCLE_CTRL    = 8'hA4;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [7:0] RST_RUN_FLAG_CTRL = 8'h00;
   localparam logic [7:0] RST_MODE_SELECT   = 8'h00;
   localparam logic [7:0] RST_COUNT         = 8'h00;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int T1_GATE  = 7;
   localparam int T1_CT    = 6;
   localparam int T1_M_HI  = 5;
   localparam int T1_M_LO  = 4;
   localparam int T0_GATE  = 3;
   localparam int T0_CT    = 2;
   localparam int T0_M_HI  = 1;
   localparam int T0_M_LO  = 0;
   localparam int TF1_POS  = 7;
   localparam int TR1_POS  = 6;
   localparam int TF0_POS  = 5;
   localparam int TR0_POS  = 4;
   localparam int IE0_POS  = 1;
   localparam int IT0_POS  = 0;
   localparam int FAST_POS = 0;

   // ***********************************************************
   // Modes and machine cycle timing
   // ***********************************************************
   localparam logic [1:0] MODE_13     = 2'h0;
   localparam logic [1:0] MODE_16     = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT  = 2'h3;
   localparam int         CYCLES_STD  = 12;
   localparam int         CYCLES_FAST = 6;
   localparam logic [3:0] LAST_STD    = 4'(CYCLES_STD - 1);
   localparam logic [3:0] LAST_FAST   = 4'(CYCLES_FAST - 1);

   localparam int APB_ADDR_W = 12;

   typedef struct packed {
      logic                  psel;
      logic                  penable;
      logic                  pwrite;
      logic [APB_ADDR_W-1:0] paddr;
      logic [31:0]           pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic timer0_count_pin;
      logic timer1_count_pin;
      logic ext_irq0_pin;
      logic ext_irq1_pin;
   } timer_pins_t;

   typedef struct packed {
      logic timer0_ack;
      logic timer1_ack;
      logic ext_irq0_ack;
   } vector_ack_t;

endpackage : timer_pkg

// >>> core_model.sv
// Purpose: Processor core stand-in on the register bus and vector acks
// Assumes: One transfer at a time, each launched just after a rising edge
// Notes:   A wait that runs past its bound is counted in hangs
module core_model
   import timer_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire apb_rsp_t apb_rsp,
   output apb_req_t      apb_req,
   output vector_ack_t   vector_ack
);
   timeunit 1ns;
   timeprecision 1ps;

   int hangs = 0;

   initial begin
      apb_req    = '0;
      vector_ack = '0;
   end

   // One bus transfer: setup, access, then wait up to 20 clocks for ready
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      apb_req <= '{1'h1, 1'h0, w, {2'h0, idx, 2'h0}, {24'h000000, wd}};
      @(posedge clk_sys);
      apb_req.penable <= 1'h1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (apb_rsp.pready !== 1'h1 && n < 20);
      if (n >= 20) hangs++;
      rd = apb_rsp.prdata[7:0];
      err = apb_rsp.pslverr;
      apb_req.psel    <= 1'h0;
      apb_req.penable <= 1'h0;
      apb_req.pwdata  <= ~apb_req.pwdata;
   endtask

   // Vector ack stands for one cycle
   task automatic pulse(input vector_ack_t a);
      @(posedge clk_sys);
      vector_ack <= a;
      @(posedge clk_sys);
      vector_ack <= '0;
   endtask
endmodule // core_model

// >>> dual_timer_counter_unit_tb.sv
// Purpose: Self-checking bench for the dual timer/counter unit
// Assumes: 12 clocks per machine cycle except 6 in the fast rate check, absent pins held high
// Notes:   Count windows allow for the unknown machine cycle phase
module dual_timer_counter_unit_tb;
   import timer_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys;
   logic        reset_n;
   apb_req_t    apb_req;
   apb_rsp_t    apb_rsp;
   timer_pins_t pins;
   vector_ack_t vector_ack;
   logic [2:0]  flg;
   logic [7:0]  rd;
   logic        err;
   int          failures = 0;
   int          check_count = 0;
   logic [24:0] rows [6] = '{{8'h89, 8'hA5, 8'hA5, 1'h0}, {8'hA0, 8'h5A, 8'h5A, 1'h0},
                             {8'hA1, 8'hC3, 8'hC3, 1'h0}, {8'hA2, 8'h3C, 8'h3C, 1'h0},
                             {8'hA3, 8'h96, 8'h96, 1'h0}, {8'h90, 8'hFF, 8'h00, 1'h1}};

   dual_timer_counter_unit uut (.clk_sys(clk_sys), .reset_n(reset_n), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .pins(pins), .vector_ack(vector_ack),
      .timer0_overflow_flag(flg[0]), .timer1_overflow_flag(flg[1]),
      .ext_irq0_request_flag(flg[2]));

   core_model core (.clk_sys(clk_sys), .apb_rsp(apb_rsp), .apb_req(apb_req),
      .vector_ack(vector_ack));

   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ***********************************************************
   // Helpers
   // ***********************************************************
   task automatic final_report;
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
      core.xfer(w, i, d, rd, err);
      if (core.hangs != 0) begin
         chk(8'h01, 8'h00, "bus hang");
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      bus(1'h1, i, d);
   endtask

   task automatic rdc(input logic [7:0] i, input logic [7:0] e, input string m);
      bus(1'h0, i, 8'h00);
      chk(rd, e, m);
   endtask

   task automatic fchk(input int w, input logic e, input string m);
      #1;
      chk({7'h00, flg[w]}, {7'h00, e}, m);
   endtask

   task automatic waitf(input int w, input int n, input string m);
      int k;
      k = 0;
      while (flg[w] !== 1'h1 && k < n) begin
         @(posedge clk_sys);
         k++;
      end
      chk({7'h00, k < n}, 8'h01, m);
      if (k >= n) final_report();
   endtask

   task automatic pin(input int b, input logic v);
      @(posedge clk_sys);
      pins[b] <= v;
   endtask

   task automatic arm(input logic [7:0] hi, input logic [7:0] th, input logic [7:0] tl,
                      input logic [7:0] md, input logic [7:0] ctl);
      wr(IDX_RUN_FLAG_CTRL, 8'h00);
      wr(hi, th);
      wr(8'(hi - 8'h01), tl);
      wr(IDX_MODE_SELECT, md);
      wr(IDX_RUN_FLAG_CTRL, ctl);
   endtask

   task automatic do_reset;
      @(posedge clk_sys);
      reset_n <= 1'h0;
      cyc(10);
      reset_n <= 1'h1;
   endtask

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      reset_n = 1'h0;
      pins    = '1;
      do_reset();
      rdc(IDX_RUN_FLAG_CTRL, 8'h00, "control after reset");
      rdc(IDX_MODE_SELECT, 8'h00, "mode after reset");
      foreach (rows[k]) begin
         wr(rows[k][24:17], rows[k][16:9]);
         rdc(rows[k][24:17], rows[k][8:1], "readback");
         chk({7'h00, err}, {7'h00, rows[k][0]}, "slave error");
      end
      arm(IDX_T0_HIGH, 8'hFF, 8'hF0, 8'h01, 8'h10);
      cyc(175);
      fchk(0, 1'h0, "count rate too fast");
      waitf(0, 30, "16-bit overflow");
      wr(IDX_RUN_FLAG_CTRL, 8'h00);
      fchk(0, 1'h0, "software clear");
      rdc(IDX_T0_LOW, 8'h00, "16-bit low wrap");
      rdc(IDX_T0_HIGH, 8'h00, "16-bit high wrap");
      wr(IDX_RUN_FLAG_CTRL, 8'h20);
      fchk(0, 1'h1, "software set");
      core.pulse(3'h4);
      fchk(0, 1'h0, "vector clear");
      arm(IDX_T0_HIGH, 8'hF0, 8'hFE, 8'h02, 8'h10);
      waitf(0, 30, "reload overflow");
      wr(IDX_RUN_FLAG_CTRL, 8'h00);
      rdc(IDX_T0_LOW, 8'hF0, "low reloaded");
      rdc(IDX_T0_HIGH, 8'hF0, "high kept");
      arm(IDX_T0_HIGH, 8'hFF, 8'hFF, 8'h00, 8'h10);
      waitf(0, 20, "13-bit overflow");
      wr(IDX_RUN_FLAG_CTRL, 8'h00);
      rdc(IDX_T0_LOW, 8'hE0, "13-bit low");
      rdc(IDX_T0_HIGH, 8'h00, "13-bit high");
      wr(IDX_CYCLE_CTRL, 8'h01);
      arm(IDX_T0_HIGH, 8'h00, 8'h00, 8'h01, 8'h10);
      cyc(60);
      bus(1'h0, IDX_T0_LOW, 8'h00);
      chk({7'h00, rd == 8'h0A || rd == 8'h0B}, 8'h01, "fast count rate");
      wr(IDX_CYCLE_CTRL, 8'h00);
      pin(1, 1'h0);
      arm(IDX_T0_HIGH, 8'h00, 8'h00, 8'h09, 8'h10);
      cyc(60);
      rdc(IDX_T0_LOW, 8'h00, "gate closed");
      pin(1, 1'h1);
      cyc(60);
      bus(1'h0, IDX_T0_LOW, 8'h00);
      chk({7'h00, rd > 8'h03}, 8'h01, "gate open");
      arm(IDX_T1_HIGH, 8'h00, 8'h00, 8'h50, 8'h40);
      repeat (3) begin
         pin(2, 1'h0);
         cyc(30);
         pin(2, 1'h1);
         cyc(30);
      end
      rdc(IDX_T1_LOW, 8'h03, "edge count");
      wr(IDX_MODE_SELECT, 8'h30);
      pin(2, 1'h0);
      cyc(30);
      pin(2, 1'h1);
      cyc(30);
      rdc(IDX_T1_LOW, 8'h03, "timer 1 held");
      arm(IDX_T0_HIGH, 8'hFF, 8'h00, 8'h03, 8'h40);
      waitf(1, 20, "split high overflow");
      wr(IDX_RUN_FLAG_CTRL, 8'h00);
      rdc(IDX_T0_LOW, 8'h00, "split low idle");
      fchk(0, 1'h0, "split low flag");
      arm(IDX_T0_HIGH, 8'h00, 8'h00, 8'h85, 8'h50);
      pin(0, 1'h0);
      repeat (2) begin
         pin(3, 1'h0);
         cyc(30);
         pin(3, 1'h1);
         cyc(30);
      end
      rdc(IDX_T0_LOW, 8'h00, "absent count pin");
      bus(1'h0, IDX_T1_LOW, 8'h00);
      chk({7'h00, rd != 8'h03}, 8'h01, "absent gate pin");
      pin(0, 1'h1);
      wr(IDX_RUN_FLAG_CTRL, 8'h01);
      pin(1, 1'h0);
      waitf(2, 40, "edge request");
      pin(1, 1'h1);
      core.pulse(3'h1);
      fchk(2, 1'h0, "edge request cleared");
      wr(IDX_RUN_FLAG_CTRL, 8'h00);
      pin(1, 1'h0);
      waitf(2, 40, "level request");
      core.pulse(3'h1);
      fchk(2, 1'h1, "level request kept");
      pin(1, 1'h1);
      cyc(30);
      fchk(2, 1'h0, "level request released");
      wr(IDX_MODE_SELECT, 8'h5A);
      wr(IDX_RUN_FLAG_CTRL, 8'h50);
      do_reset();
      rdc(IDX_RUN_FLAG_CTRL, 8'h00, "control after second reset");
      rdc(IDX_MODE_SELECT, 8'h00, "mode after second reset");
      final_report();
   end

   initial begin
      #500us;
      chk(8'h01, 8'h00, "run watchdog");
      final_report();
   end
endmodule // dual_timer_counter_unit_tb
